// ### pkg/oscwu_pkg.sv
// Purpose: Shared constants and types of the oscillator warm-up counter
// Assumes: Word-aligned AHB-Lite register map, byte offsets below
// Notes:   Every field position and code used by more than one file lives here

package oscwu_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_LOWER_CTRL = 8'h00;
  localparam logic [7:0] OFS_UPPER_CTRL = 8'h04;
  localparam logic [7:0] OFS_COMPARE    = 8'h08;
  localparam logic [7:0] OFS_SYS_CTRL   = 8'h0c;
  localparam logic [7:0] OFS_COUNT      = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;
  localparam logic [7:0] OFS_STATE      = 8'h1c;

  // ----------------------------------------------------------------------
  // Timer control fields
  // ----------------------------------------------------------------------
  localparam int         MODE_LSB      = 0;
  localparam int         MODE_W        = 3;
  localparam int         SRC_LSB       = 4;
  localparam int         SRC_W         = 3;
  localparam int         RUN_BIT       = 3;
  localparam int         FLOP_INIT_BIT = 7;
  localparam logic [2:0] MODE_CASCADE  = 3'h3;
  localparam logic [2:0] MODE_WARMUP   = 3'h5;
  localparam logic [2:0] SRC_LOW_FREQ  = 3'h4;
  localparam logic [2:0] SRC_HIGH_FREQ = 3'h6;

  // ----------------------------------------------------------------------
  // System clock control fields
  // ----------------------------------------------------------------------
  localparam int HIGH_OSC_BIT  = 7;
  localparam int LOW_OSC_BIT   = 6;
  localparam int LOW_CLOCK_BIT = 5;

  // ----------------------------------------------------------------------
  // Reset values, bus codes, interrupt bits
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_LOWER_CTRL = 8'h00;
  localparam logic [7:0]  RST_UPPER_CTRL = 8'h00;
  localparam logic [15:0] RST_COMPARE    = 16'h0000;
  localparam logic [7:0]  RST_SYS_CTRL   = 8'h80;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;
  localparam int          IRQ_MATCH_BIT  = 0;
  localparam int          CMP_UPPER_LSB  = 8;

  typedef enum logic [2:0] {
    OSCWU_IDLE = 3'b001,
    OSCWU_RUN  = 3'b010,
    OSCWU_DONE = 3'b100
  } oscwu_state_t;

endpackage

// ### logic/oscwu_edge.sv
// Purpose: Turns the selected source clock into one-cycle count ticks
// Assumes: Source clock inputs are synchronous to hclk and slower than it
// Notes:   A source that is not selected produces no ticks

`timescale 1ns/1ps
`default_nettype none

module oscwu_edge (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic sel_low,
  input  wire logic sel_high,
  input  wire logic low_freq_clock,
  input  wire logic high_freq_clock,
  output wire logic tick
);
  import oscwu_pkg::*;

  typedef struct packed {
    logic prev_low;
    logic prev_high;
  } oscwu_edge_t;

  oscwu_edge_t r;
  oscwu_edge_t next_r;

  // ----------------------------------------------------------------------
  // Rising edge of the chosen source
  // ----------------------------------------------------------------------
  always_comb begin
    next_r.prev_low  = low_freq_clock;
    next_r.prev_high = high_freq_clock;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = (sel_low & low_freq_clock & ~r.prev_low) |
                (sel_high & high_freq_clock & ~r.prev_high);

endmodule

`default_nettype wire

// ### logic/oscwu_count.sv
// Purpose: Cascaded 16-bit up-counter with upper-byte compare
// Assumes: One enable pulse per source clock edge
// Notes:   Clear beats both count and match in the same cycle

`timescale 1ns/1ps
`default_nettype none

module oscwu_count (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clear,
  input  wire logic        enable,
  input  wire logic [7:0]  cmp_upper,
  output wire logic [15:0] count,
  output wire logic        match
);
  import oscwu_pkg::*;

  typedef struct packed {
    logic [15:0] count;
  } oscwu_count_t;

  oscwu_count_t r;
  oscwu_count_t next_r;
  logic [15:0]  incremented;

  assign incremented = r.count + 16'h0001;
  // Low byte of the compare takes no part in the match
  assign match = enable & ~clear & (incremented[15:CMP_UPPER_LSB] == cmp_upper);

  // ----------------------------------------------------------------------
  // Count, clear on match, hold when idle
  // ----------------------------------------------------------------------
  always_comb begin
    next_r = r;
    if (clear) begin
      next_r.count = 16'h0000;
    end else if (match) begin
      next_r.count = 16'h0000;
    end else if (enable) begin
      next_r.count = incremented;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign count = r.count;

endmodule

`default_nettype wire

// ### logic/oscwu_top.sv
// Purpose: Oscillator warm-up counter with AHB-Lite register access
// Assumes: Source clocks are synchronous inputs slower than hclk
// Notes:   Zero-wait slave; reads return data one cycle after address
//          A restart always counts from zero; the low compare byte is kept but unused
//
// Chosen here: the AHB-Lite slave port and the register addresses.

`timescale 1ns/1ps
`default_nettype none

module oscwu_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output wire logic [31:0] hrdata,
  output wire logic        hreadyout,
  output wire logic        hresp,
  input  wire logic        low_freq_clock,
  input  wire logic        high_freq_clock,
  output wire logic        high_osc_enable,
  output wire logic        low_osc_enable,
  output wire logic        low_clock_select,
  output wire logic        irq
);
  import oscwu_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]   lower_timer_control;
    logic [7:0]   upper_timer_control;
    logic [15:0]  compare;
    logic [7:0]   system_clock_control;
    logic         irq_status;
    logic         irq_mask;
    oscwu_state_t state;
    logic         dp_valid;
    logic         dp_write;
    logic [7:0]   dp_addr;
    logic [31:0]  rdata;
  } oscwu_regs_t;

  localparam oscwu_regs_t RESET_REGS = '{
    lower_timer_control:  RST_LOWER_CTRL,
    upper_timer_control:  RST_UPPER_CTRL,
    compare:              RST_COMPARE,
    system_clock_control: RST_SYS_CTRL,
    irq_status:           1'b0,
    irq_mask:             1'b0,
    state:                OSCWU_IDLE,
    dp_valid:             1'b0,
    dp_write:             1'b0,
    dp_addr:              8'h00,
    rdata:                32'h0000_0000
  };

  oscwu_regs_t r;
  oscwu_regs_t next_r;

  logic        take;
  logic        wr_phase;
  logic        wr_upper;
  logic        start;
  logic        w1c_match;
  logic        warmup_armed;
  logic        active;
  logic        sel_low;
  logic        sel_high;
  logic        tick;
  logic        cnt_match;
  logic [15:0] count;
  logic [2:0]  lower_mode;
  logic [2:0]  upper_mode;
  logic [2:0]  src_sel;
  logic        sel_ok;
  logic        trans_ok;
  logic        size_ok;
  logic        ap_mapped;
  logic        dp_mapped;
  logic        run_now;
  logic        run_next;
  logic        run_off;
  logic        cnt_clear;
  logic        cnt_enable;
  logic [7:0]  cmp_upper;
  logic        irq_set;
  logic        irq_clear;
  logic        irq_next;
  logic        irq_pend;

  // ----------------------------------------------------------------------
  // Decode of the stored controls
  // ----------------------------------------------------------------------
  assign lower_mode = r.lower_timer_control[MODE_LSB +: MODE_W];
  assign upper_mode = r.upper_timer_control[MODE_LSB +: MODE_W];
  assign src_sel    = r.lower_timer_control[SRC_LSB +: SRC_W];

  // 43H and 63H both mean cascaded operation with flop init zero
  assign warmup_armed = (upper_mode == MODE_WARMUP) &&
                        (lower_mode == MODE_CASCADE);
  // Prescaled sources are not modelled, so any other code never ticks
  assign sel_low  = (src_sel == SRC_LOW_FREQ);
  assign sel_high = (src_sel == SRC_HIGH_FREQ);
  assign active   = warmup_armed && r.upper_timer_control[RUN_BIT];

  // ----------------------------------------------------------------------
  // Address decode, one compare per register slot in each bus phase
  // ----------------------------------------------------------------------
  // Slot order follows the register map; the index is the offset over four
  localparam int         REG_SLOTS = 8;
  localparam logic [7:0] SLOT_OFS [REG_SLOTS] = '{
    OFS_LOWER_CTRL,
    OFS_UPPER_CTRL,
    OFS_COMPARE,
    OFS_SYS_CTRL,
    OFS_COUNT,
    OFS_IRQ_STATUS,
    OFS_IRQ_MASK,
    OFS_STATE
  };

  // Hits of the address phase and of the data phase
  logic [REG_SLOTS-1:0] ap_hit;
  logic [REG_SLOTS-1:0] dp_hit;

  for (genvar i = 0; i < REG_SLOTS; i++) begin : g_slot
    assign ap_hit[i] = (haddr[7:0] == SLOT_OFS[i]);
    assign dp_hit[i] = (r.dp_addr == SLOT_OFS[i]);
  end

  // Misaligned and unmapped addresses fall out here and read as zero
  assign ap_mapped = |ap_hit;
  assign dp_mapped = |dp_hit;

  // ----------------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------------
  assign sel_ok   = hsel && hready;
  // NONSEQ and SEQ carry a transfer, IDLE and BUSY do not
  assign trans_ok = htrans[1];
  // Narrow accesses are dropped but still answered OKAY
  assign size_ok  = (hsize == HSIZE_WORD);
  assign take     = sel_ok && trans_ok && size_ok;
  // Writes land at the end of the data phase, with hwdata as it stands then
  assign wr_phase = r.dp_valid && r.dp_write && dp_mapped;
  assign wr_upper = wr_phase && (r.dp_addr == OFS_UPPER_CTRL);
  // Only a zero-to-one change of the run bit restarts the count
  assign start    = wr_upper && hwdata[RUN_BIT] &&
                    !r.upper_timer_control[RUN_BIT];
  assign w1c_match = wr_phase && (r.dp_addr == OFS_IRQ_STATUS) &&
                     hwdata[IRQ_MATCH_BIT];

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  assign run_now  = r.upper_timer_control[RUN_BIT];
  assign run_next = wr_upper ? hwdata[RUN_BIT] : run_now;
  // Any write that leaves the run bit low ends a run or a finished wait
  assign run_off  = !run_next;
  // A restart clears the count; a stopped or unarmed counter never ticks
  assign cnt_clear  = start;
  assign cnt_enable = active && tick;
  assign cmp_upper  = r.compare[15:CMP_UPPER_LSB];

  // ----------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------
  // Set wins, so a match landing on the clearing write is never lost
  assign irq_set   = cnt_match;
  assign irq_clear = w1c_match && !irq_set;
  assign irq_next  = irq_set | (r.irq_status & ~irq_clear);
  // Level output; software drops it through the status register
  assign irq_pend  = r.irq_status & r.irq_mask;

  // ----------------------------------------------------------------------
  // Source edge detector and cascaded counter
  // ----------------------------------------------------------------------
  oscwu_edge u_edge (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .sel_low         (sel_low),
    .sel_high        (sel_high),
    .low_freq_clock  (low_freq_clock),
    .high_freq_clock (high_freq_clock),
    .tick            (tick)
  );

  oscwu_count u_count (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clear     (cnt_clear),
    .enable    (cnt_enable),
    .cmp_upper (cmp_upper),
    .count     (count),
    .match     (cnt_match)
  );

  // ----------------------------------------------------------------------
  // Read mux, evaluated on the register state that the edge will store and the present count
  // ----------------------------------------------------------------------
  function automatic logic [31:0] read_word(input oscwu_regs_t s,
                                            input logic [15:0] cnt);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (s.dp_addr)
      OFS_LOWER_CTRL: begin
        w[7:0] = s.lower_timer_control;
      end
      OFS_UPPER_CTRL: begin
        w[7:0] = s.upper_timer_control;
      end
      OFS_COMPARE: begin
        w[15:0] = s.compare;
      end
      OFS_SYS_CTRL: begin
        w[7:0] = s.system_clock_control;
      end
      OFS_COUNT: begin
        w[15:0] = cnt;
      end
      OFS_IRQ_STATUS: begin
        w[IRQ_MATCH_BIT] = s.irq_status;
      end
      OFS_IRQ_MASK: begin
        w[IRQ_MATCH_BIT] = s.irq_mask;
      end
      OFS_STATE: begin
        w[2:0] = s.state;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_r = r;

    if (wr_phase) begin
      case (r.dp_addr)
        OFS_LOWER_CTRL: begin
          next_r.lower_timer_control = hwdata[7:0];
        end
        OFS_UPPER_CTRL: begin
          // Run bit lives here; clearing it freezes the count
          next_r.upper_timer_control = hwdata[7:0];
        end
        OFS_COMPARE: begin
          next_r.compare = hwdata[15:0];
        end
        OFS_SYS_CTRL: begin
          next_r.system_clock_control = hwdata[7:0];
        end
        OFS_IRQ_MASK: begin
          next_r.irq_mask = hwdata[IRQ_MATCH_BIT];
        end
        default: begin
          next_r.lower_timer_control = r.lower_timer_control;
        end
      endcase
    end

    next_r.irq_status = irq_next;

    case (r.state)
      OSCWU_IDLE: begin
        if (start) begin
          next_r.state = OSCWU_RUN;
        end
      end
      OSCWU_RUN: begin
        if (run_off) begin
          next_r.state = OSCWU_IDLE;
        end else if (cnt_match) begin
          next_r.state = OSCWU_DONE;
        end
      end
      OSCWU_DONE: begin
        if (run_off) begin
          next_r.state = OSCWU_IDLE;
        end
      end
      default: begin
        next_r.state = OSCWU_IDLE;
      end
    endcase

    next_r.dp_valid = take;
    next_r.dp_write = hwrite;
    next_r.dp_addr  = haddr[7:0];
    if (take && !hwrite) begin
      next_r.rdata = ap_mapped ? read_word(next_r, count) : 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= RESET_REGS;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hrdata           = r.rdata;
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign high_osc_enable  = r.system_clock_control[HIGH_OSC_BIT];
  assign low_osc_enable   = r.system_clock_control[LOW_OSC_BIT];
  assign low_clock_select = r.system_clock_control[LOW_CLOCK_BIT];
  assign irq              = irq_pend;

endmodule

`default_nettype wire

// ### sim/oscwu_chk.sv
// Purpose: Port-level assertions for the oscillator warm-up counter
// Assumes: One hclk domain; hready is hreadyout
// Notes:   Small helper flops track bus phases and source edges

`timescale 1ns/1ps
`default_nettype none

module oscwu_chk
  import oscwu_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  input  wire logic        low_freq_clock,
  input  wire logic        high_freq_clock,
  input  wire logic        high_osc_enable,
  input  wire logic        low_osc_enable,
  input  wire logic        low_clock_select,
  input  wire logic        irq
);
  // --------------------
  // Helper state
  // --------------------
  logic       rd_q;
  logic       wr_q;
  logic       run_q;
  logic       lf_q;
  logic       hf_q;
  logic [7:0] addr_q;
  wire logic  take = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
  wire logic  sys_wr = wr_q && (addr_q == OFS_SYS_CTRL);
  wire logic  msk_wr = wr_q && (addr_q == OFS_IRQ_MASK);
  wire logic  clr_wr = wr_q && (addr_q == OFS_IRQ_STATUS || addr_q == OFS_IRQ_MASK);
  wire logic  rise = (low_freq_clock && !lf_q) || (high_freq_clock && !hf_q);
  wire logic [2:0] pins = {high_osc_enable, low_osc_enable, low_clock_select};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
      run_q  <= 1'b0;
      lf_q   <= 1'b0;
      hf_q   <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      rd_q   <= take && !hwrite;
      wr_q   <= take && hwrite;
      addr_q <= haddr[7:0];
      lf_q   <= low_freq_clock;
      hf_q   <= high_freq_clock;
      if (wr_q && addr_q == OFS_UPPER_CTRL) begin
        run_q <= hwdata[RUN_BIT];
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // --------------------
  // Properties
  // --------------------
  property p_sys_write;
    sys_wr |=> pins == $past(hwdata[7:5]);
  endproperty
  a_sys_write: assert property (p_sys_write) else $error("sys pins not written");
  property p_sys_hold;
    !sys_wr |=> $stable(pins);
  endproperty
  a_sys_hold: assert property (p_sys_hold) else $error("sys pins moved alone");
  property p_sys_read;
    rd_q && addr_q == OFS_SYS_CTRL |-> hrdata[7:5] == pins && hrdata[31:8] == 24'h0;
  endproperty
  a_sys_read: assert property (p_sys_read) else $error("sys readback wrong");
  property p_reset_vals;
    $rose(hresetn) |-> pins == 3'h4 && !irq;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad outputs after reset");
  property p_irq_rise;
    $rose(irq) |-> $past(msk_wr || (run_q && rise));
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_fall;
    $fell(irq) |-> $past(clr_wr);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
  property p_state_read;
    rd_q && addr_q == OFS_STATE |-> $onehot(hrdata[2:0]) && hrdata[31:3] == 29'h0;
  endproperty
  a_state_read: assert property (p_state_read) else $error("state not one-hot");
  property p_count_read;
    rd_q && addr_q == OFS_COUNT |-> hrdata[31:16] == 16'h0;
  endproperty
  a_count_read: assert property (p_count_read) else $error("count wider than 16");

  c_irq: cover property ($rose(irq));
  c_sys: cover property (sys_wr);
  c_done: cover property (rd_q && addr_q == OFS_STATE && hrdata[2]);
endmodule

bind oscwu_top oscwu_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .low_freq_clock(low_freq_clock), .high_freq_clock(high_freq_clock),
  .high_osc_enable(high_osc_enable), .low_osc_enable(low_osc_enable),
  .low_clock_select(low_clock_select), .irq(irq)
);

`default_nettype wire

// ### sim/oscillator_warmup_counter_bench.sv
// Purpose: Self-checking bench for the oscillator warm-up counter
// Assumes: Zero-wait AHB-Lite slave, source clocks driven synchronously
// Notes:   Only compare upper byte 01 runs; the maximum would take too long

`timescale 1ns/1ps
`default_nettype none

module oscillator_warmup_counter_bench;
  import oscwu_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, low_freq_clock, high_freq_clock;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire logic [31:0] hrdata;
  wire logic   hready, hreadyout, hresp, high_osc_enable, low_osc_enable, low_clock_select, irq;
  int          error_cnt, cmp_count;
  logic [31:0] rstv [8] = '{32'h0, 32'h0, 32'h0, 32'h80, 32'h0, 32'h0, 32'h0, 32'h1};

  assign hready = hreadyout;
  always #50 hclk = ~hclk;

  oscwu_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .low_freq_clock(low_freq_clock),
    .high_freq_clock(high_freq_clock), .high_osc_enable(high_osc_enable),
    .low_osc_enable(low_osc_enable), .low_clock_select(low_clock_select), .irq(irq)
  );

  // --------------------
  // Bus and check tasks
  // --------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_rdy;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= 1'b1;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    @(posedge hclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    haddr  <= {24'h0, a};
    hwrite <= 1'b0;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    wait_rdy();
    chk($sformatf("reg %h", a), hrdata, e);
  endtask
  // Source pulses stay high one hclk cycle and low the next, so every edge is seen
  task automatic pulse(input logic hi, input int n);
    repeat (n) begin
      if (hi) begin
        high_freq_clock <= 1'b1;
      end else begin
        low_freq_clock <= 1'b1;
      end
      @(posedge hclk);
      low_freq_clock  <= 1'b0;
      high_freq_clock <= 1'b0;
      @(posedge hclk);
    end
  endtask
  function automatic logic [31:0] pins();
    return {29'h0, high_osc_enable, low_osc_enable, low_clock_select};
  endfunction
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    complete_run();
  end

  // --------------------
  // Test sequence
  // --------------------
  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b1; hsize = HSIZE_WORD; htrans = 2'b00;
    hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0; low_freq_clock = 1'b0; high_freq_clock = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_chk(8'(4 * i), rstv[i]);
    end
    chk("pins", pins(), 32'h4);
    wr(8'h20, 32'hffffffff);
    rd_chk(8'h20, 32'h0);
    chk("ready resp", {30'h0, hreadyout, hresp}, 32'h2);
    wr(OFS_COUNT, 32'h1234);
    rd_chk(OFS_COUNT, 32'h0);
    wr(OFS_SYS_CTRL, 32'he0);
    chk("pins", pins(), 32'h7);
    wr(OFS_SYS_CTRL, 32'h40);
    chk("pins", pins(), 32'h2);
    // Toward the low clock; lower compare byte must not matter
    wr(OFS_SYS_CTRL, 32'hc0);
    wr(OFS_LOWER_CTRL, 32'h43);
    wr(OFS_UPPER_CTRL, 32'h05);
    wr(OFS_COMPARE, 32'h01ff);
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_UPPER_CTRL, 32'h0d);
    rd_chk(OFS_STATE, 32'h2);
    pulse(1'b0, 255);
    pulse(1'b1, 10);
    rd_chk(OFS_COUNT, 32'hff);
    rd_chk(OFS_IRQ_STATUS, 32'h0);
    pulse(1'b0, 1);
    rd_chk(OFS_COUNT, 32'h0);
    rd_chk(OFS_IRQ_STATUS, 32'h1);
    chk("irq", 32'(irq), 32'h1);
    rd_chk(OFS_STATE, 32'h4);
    wr(OFS_IRQ_STATUS, 32'h1);
    chk("irq", 32'(irq), 32'h0);
    pulse(1'b0, 3);
    wr(OFS_UPPER_CTRL, 32'h05);
    rd_chk(OFS_STATE, 32'h1);
    pulse(1'b0, 3);
    rd_chk(OFS_COUNT, 32'h3);
    wr(OFS_SYS_CTRL, 32'he0);
    wr(OFS_SYS_CTRL, 32'h60);
    chk("pins", pins(), 32'h3);
    // Toward the high clock, interrupt masked
    wr(OFS_SYS_CTRL, 32'he0);
    wr(OFS_LOWER_CTRL, 32'h63);
    wr(OFS_COMPARE, 32'h0100);
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_UPPER_CTRL, 32'h0d);
    rd_chk(OFS_COUNT, 32'h0);
    pulse(1'b0, 20);
    rd_chk(OFS_COUNT, 32'h0);
    pulse(1'b1, 256);
    rd_chk(OFS_IRQ_STATUS, 32'h1);
    chk("irq", 32'(irq), 32'h0);
    wr(OFS_IRQ_STATUS, 32'h1);
    rd_chk(OFS_IRQ_STATUS, 32'h0);
    wr(OFS_UPPER_CTRL, 32'h05);
    wr(OFS_SYS_CTRL, 32'hc0);
    wr(OFS_SYS_CTRL, 32'h80);
    chk("pins", pins(), 32'h4);
    // Run bit without warm-up mode: the start clears, nothing counts
    wr(OFS_UPPER_CTRL, 32'h08);
    pulse(1'b1, 3);
    rd_chk(OFS_COUNT, 32'h0);
    complete_run();
  end
endmodule

`default_nettype wire
